// file: verilog/twem_pkg.sv
// Shared constants and types of the two-wire EEPROM master
package twem_pkg;
   // Clock rate and serial clock rate
   localparam int CLK_MHZ       = 250;
   localparam int SCL_PERIOD_NS = 2500;
   localparam int QTR_CYC       = (SCL_PERIOD_NS * CLK_MHZ) / (4 * 1000);
   localparam logic [7:0] QTR_RELOAD = 8'(QTR_CYC - 1);
   // Longest self-timed write; the poll loop gives up after it
   localparam int WR_TIME_MS = 5;
   localparam int WR_CYC     = WR_TIME_MS * CLK_MHZ * 1000;
   // Array and frame layout
   localparam int ADDR_W     = 15;
   localparam int AHI_LSB    = 8;
   localparam int DATA_W     = 8;
   localparam int LEN_W      = 7;
   localparam int FIFO_DEPTH = 4;
   localparam logic [LEN_W-1:0] PAGE_BYTES = 7'h40;
   localparam logic [LEN_W-1:0] LEN_LAST   = 7'h01;
   localparam logic [3:0] BIT_ACK     = 4'h8;
   localparam logic [3:0] RECOV_LAST  = 4'h8;
   localparam logic [3:0] RECOV_PULSES = 4'h9;
   // Quarter phases of one serial clock bit
   localparam logic [1:0] PH_LOW  = 2'h0;
   localparam logic [1:0] PH_RISE = 2'h1;
   localparam logic [1:0] PH_HIGH = 2'h2;
   localparam logic [1:0] PH_FALL = 2'h3;

   typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_CUR_READ, OP_RECOVER} twem_op_t;

   typedef struct packed {
      twem_op_t          op;
      logic [2:0]        sel;
      logic [ADDR_W-1:0] addr;
      logic [LEN_W-1:0]  len;
   } twem_cmd_t;
endpackage

// file: verilog/twem_fifo.sv
// Small first-in first-out buffer for write data
`timescale 1ns/1ps
`default_nettype none
module twem_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wp_q;
   logic [AW:0]      rp_q;
   wire logic        push;
   wire logic        pop;

   // Extra pointer bit tells full from empty; depth must be a power of two
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign in_ready  = (wp_q - rp_q) != (AW + 1)'(DEPTH);
   assign out_valid = wp_q != rp_q;
   assign out_data  = mem_q[rp_q[AW-1:0]];

   // Pointers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         if (push) wp_q <= wp_q + (AW + 1)'(1);
         if (pop) rp_q <= rp_q + (AW + 1)'(1);
      end
   end

   // Storage, no reset needed
   always_ff @(posedge clk) begin
      if (push) mem_q[wp_q[AW-1:0]] <= in_data;
   end
endmodule
`default_nettype wire

// file: verilog/twem_ctrl.sv
// Bus master that drives a two-wire serial EEPROM through its pins
// Notes on behaviour
// - Stop: data rises, clock high; every operation ends so
// - Receiver of a byte pulls data low to acknowledge
// - Start resets device; up to nine recovery pulses first
// - Address lowest bit: one reads, zero writes
// - Byte write: address, memory address, data, stop
// - Page write: up to 64 bytes, each acknowledged
// - Poll with write address until device acknowledges
// - Master refuses acknowledge on single read, then stops
// - Random read: dummy write, repeated start, read
// - Acknowledge continues sequential read; no acknowledge ends
`timescale 1ns/1ps
`default_nettype none
module twem_ctrl #(
   parameter int         WR_CYC   = twem_pkg::WR_CYC,
   parameter logic [3:0] DEV_TYPE = 4'h5 // Arbitrary value, set to the part's type code
) (
   input  wire logic                        ref_clk,
   input  wire logic                        rst_n,
   input  wire twem_pkg::twem_cmd_t         cmd,
   input  wire logic                        cmd_valid,
   output logic                             cmd_ready,
   input  wire logic [twem_pkg::DATA_W-1:0] wr_data,
   input  wire logic                        wr_valid,
   output logic                             wr_ready,
   output logic [twem_pkg::DATA_W-1:0]      rd_data,
   output logic                             rd_valid,
   output logic                             done,
   output logic                             nack_err,
   output logic                             busy_err,
   output logic                             scl_o,
   input  wire logic                        sda_i,
   output logic                             sda_o,
   output logic                             sda_oe
);
   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_TX, ST_RX, ST_FETCH, ST_STOP, ST_RECOV}
      twem_state_t;
   typedef enum logic [2:0] {SQ_CTRL, SQ_AHI, SQ_ALO, SQ_WDATA, SQ_CTRL_R, SQ_POLL, SQ_RECOV}
      twem_seq_t;

   twem_state_t                  st_q;
   twem_seq_t                    seq_q;
   twem_pkg::twem_cmd_t          cmd_q;
   logic [7:0]                   div_q;
   logic [1:0]                   ph_q;
   logic [3:0]                   bit_q;
   logic [3:0]                   rcnt_q;
   logic [7:0]                   sh_q;
   logic [twem_pkg::LEN_W-1:0]   left_q;
   logic [31:0]                  wt_q;
   logic                         poll_q;
   logic                         samp_q;
   logic                         sda_s1_q;
   logic                         sda_s2_q;
   wire logic                    tick;
   wire logic                    active;
   wire logic                    bit_done;
   wire logic                    sample;
   wire logic                    scl_hi;
   wire logic                    scl_d;
   wire logic                    sda_low;
   wire logic                    at_ack;
   wire logic                    last;
   wire logic                    ack_ok;
   wire logic                    expired;
   wire logic                    go;
   wire logic [7:0]              ctrl_byte;
   wire logic [twem_pkg::DATA_W-1:0] fifo_data;
   wire logic                    fifo_valid;
   wire logic                    fifo_pop;

   // Write data wait here; the engine stalls with the clock low while it is empty
   twem_fifo #(
      .WIDTH (twem_pkg::DATA_W),
      .DEPTH (twem_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (ref_clk),
      .rst_n     (rst_n),
      .in_data   (wr_data),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop)
   );

   // Data line comes from outside; two flops before anything reads it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_s1_q <= 1'h1;
         sda_s2_q <= 1'h1;
      end else begin
         sda_s1_q <= sda_i;
         sda_s2_q <= sda_s1_q;
      end
   end

   // Free-running quarter-bit divider; first phase after a command may be short
   assign tick = (div_q == '0);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) div_q <= twem_pkg::QTR_RELOAD;
      else div_q <= tick ? twem_pkg::QTR_RELOAD : div_q - 8'h01;
   end

   // Phase and decode of the current step
   assign active    = (st_q != ST_IDLE) && (st_q != ST_FETCH);
   assign bit_done  = tick && active && (ph_q == twem_pkg::PH_FALL);
   assign sample    = tick && active && (ph_q == twem_pkg::PH_HIGH);
   assign at_ack    = (bit_q == twem_pkg::BIT_ACK);
   assign last      = (left_q == twem_pkg::LEN_LAST);
   assign ack_ok    = !samp_q;
   assign expired   = (wt_q >= 32'(WR_CYC));
   assign go        = cmd_valid && cmd_ready;
   assign cmd_ready = (st_q == ST_IDLE);
   assign fifo_pop  = (st_q == ST_FETCH);
   assign ctrl_byte = {DEV_TYPE, cmd_q.sel, seq_q == SQ_CTRL_R};

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) ph_q <= twem_pkg::PH_LOW;
      else if (tick && active) ph_q <= ph_q + 2'h1;
   end

   // Pin levels: start drops data in the high phase, stop raises it there
   assign scl_hi  = (ph_q == twem_pkg::PH_RISE) || (ph_q == twem_pkg::PH_HIGH);
   assign scl_d   = (st_q == ST_IDLE)
                  || (active && (scl_hi || (st_q == ST_STOP && ph_q == twem_pkg::PH_FALL)));
   assign sda_low = ((st_q == ST_START) && ph_q[1])
                  || ((st_q == ST_STOP) && !ph_q[1])
                  || ((st_q == ST_TX) && !at_ack && !sh_q[7])
                  || ((st_q == ST_RX) && at_ack && !last);
   assign sda_o   = 1'h0; // Open drain: only ever pulls low

   // Registered pins keep decode glitches off the wires
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_o  <= 1'h1;
         sda_oe <= 1'h0;
      end else begin
         scl_o  <= scl_d;
         sda_oe <= sda_low;
      end
   end

   // Data line captured at the end of the high phase, just before the clock falls
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) samp_q <= 1'h1;
      else if (sample) samp_q <= sda_s2_q;
   end

   // Busy wait measured from the stop that ends a write
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) wt_q <= '0;
      else if (seq_q != SQ_POLL) wt_q <= '0;
      else if (!expired) wt_q <= wt_q + 32'h1;
   end

   // Frame sequencer; steps move at the end of a bit, except when a command is taken or write data leave the buffer
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q     <= ST_IDLE;
         seq_q    <= SQ_CTRL;
         cmd_q    <= '0;
         bit_q    <= '0;
         rcnt_q   <= '0;
         sh_q     <= '0;
         left_q   <= '0;
         poll_q   <= 1'h0;
         rd_data  <= '0;
         rd_valid <= 1'h0;
         done     <= 1'h0;
         nack_err <= 1'h0;
         busy_err <= 1'h0;
      end else begin
         done     <= 1'h0;
         rd_valid <= 1'h0;
         if (go) begin
            cmd_q    <= cmd;
            left_q   <= cmd.len;
            nack_err <= 1'h0;
            busy_err <= 1'h0;
            poll_q   <= 1'h0;
            rcnt_q   <= '0;
            seq_q    <= (cmd.op == twem_pkg::OP_CUR_READ) ? SQ_CTRL_R : SQ_CTRL;
            st_q     <= (cmd.op == twem_pkg::OP_RECOVER) ? ST_RECOV : ST_START;
         end else if (st_q == ST_FETCH) begin
            if (fifo_valid) begin
               sh_q  <= fifo_data;
               bit_q <= '0;
               st_q  <= ST_TX;
            end
         end else if (bit_done) begin
            unique case (st_q)
               ST_START: begin
                  bit_q <= '0;
                  sh_q  <= ctrl_byte;
                  st_q  <= (seq_q == SQ_RECOV) ? ST_STOP : ST_TX;
               end
               ST_TX: begin
                  if (!at_ack) begin
                     bit_q <= bit_q + 4'h1;
                     sh_q  <= {sh_q[6:0], 1'h0};
                  end else if (!ack_ok) begin
                     // Refusal during polling means still busy; elsewhere it aborts
                     poll_q   <= (seq_q == SQ_POLL);
                     nack_err <= (seq_q != SQ_POLL);
                     st_q     <= ST_STOP;
                  end else begin
                     bit_q <= '0;
                     unique case (seq_q)
                        SQ_CTRL: begin
                           seq_q <= SQ_AHI;
                           sh_q  <= 8'(cmd_q.addr >> twem_pkg::AHI_LSB);
                        end
                        SQ_AHI: begin
                           seq_q <= SQ_ALO;
                           sh_q  <= 8'(cmd_q.addr);
                        end
                        SQ_ALO: begin
                           if (cmd_q.op == twem_pkg::OP_WRITE) begin
                              seq_q <= SQ_WDATA;
                              st_q  <= ST_FETCH;
                           end else begin
                              seq_q <= SQ_CTRL_R;
                              st_q  <= ST_START;
                           end
                        end
                        SQ_WDATA: begin
                           left_q <= left_q - twem_pkg::LEN_LAST;
                           poll_q <= last;
                           st_q   <= last ? ST_STOP : ST_FETCH;
                        end
                        SQ_CTRL_R: st_q <= ST_RX;
                        SQ_POLL: begin
                           poll_q <= 1'h0;
                           st_q   <= ST_STOP;
                        end
                        default: st_q <= ST_STOP;
                     endcase
                  end
               end
               ST_RX: begin
                  if (!at_ack) begin
                     bit_q <= bit_q + 4'h1;
                     sh_q  <= {sh_q[6:0], samp_q};
                  end else begin
                     bit_q    <= '0;
                     rd_data  <= sh_q;
                     rd_valid <= 1'h1;
                     left_q   <= left_q - twem_pkg::LEN_LAST;
                     st_q     <= last ? ST_STOP : ST_RX;
                  end
               end
               ST_STOP: begin
                  if (poll_q && !expired) begin
                     seq_q <= SQ_POLL;
                     st_q  <= ST_START;
                  end else begin
                     busy_err <= poll_q;
                     seq_q    <= SQ_CTRL;
                     done     <= 1'h1;
                     st_q     <= ST_IDLE;
                  end
               end
               ST_RECOV: begin
                  // Released data line means the device let go; at most nine pulses
                  if (samp_q || rcnt_q == twem_pkg::RECOV_LAST) begin
                     seq_q <= SQ_RECOV;
                     st_q  <= ST_START;
                  end else begin
                     rcnt_q <= rcnt_q + 4'h1;
                  end
               end
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_bit_end;
      tick && active && (ph_q == twem_pkg::PH_FALL);
   endsequence

   sequence s_wr_stop;
      (st_q == ST_STOP) && poll_q && !expired ##0 s_bit_end;
   endsequence

   bus_idle_a: assert property ((st_q == ST_IDLE) |=> scl_o && !sda_oe)
      else $error("bus not released while idle");
   start_shape_a: assert property (
      (st_q == ST_START && ph_q == twem_pkg::PH_HIGH) |-> scl_d && sda_low)
      else $error("start not made with clock high");
   stop_shape_a: assert property (
      (st_q == ST_STOP && ph_q == twem_pkg::PH_HIGH) |-> scl_d && !sda_low)
      else $error("stop not made with clock high");
   ctrl_byte_a: assert property (
      ((st_q == ST_START) && (seq_q != SQ_RECOV) ##0 s_bit_end)
      |=> (sh_q[7:4] == DEV_TYPE) && (sh_q[3:1] == cmd_q.sel)
          && (sh_q[0] == (seq_q == SQ_CTRL_R)) && (st_q == ST_TX))
      else $error("address byte wrong");
   addr_order_a: assert property (
      ((st_q == ST_TX) && (seq_q == SQ_CTRL) && at_ack && ack_ok ##0 s_bit_end)
      |=> (seq_q == SQ_AHI) && (sh_q == 8'(cmd_q.addr >> twem_pkg::AHI_LSB)))
      else $error("high address byte not sent first");
   rd_ack_a: assert property (
      (st_q == ST_RX && at_ack && !last) |-> sda_low)
      else $error("read byte not acknowledged");
   rd_nack_a: assert property (
      ((st_q == ST_RX) && at_ack && last ##0 s_bit_end) |-> !sda_low ##1 (st_q == ST_STOP))
      else $error("last read byte not refused and stopped");
   page_len_a: assert property (
      (st_q == ST_TX && seq_q == SQ_WDATA) |-> left_q <= twem_pkg::PAGE_BYTES)
      else $error("page write longer than a page");
   poll_next_a: assert property (s_wr_stop |=> (st_q == ST_START) && (seq_q == SQ_POLL))
      else $error("no poll after write stop");
   recov_cap_a: assert property (
      (st_q == ST_RECOV) |-> rcnt_q < twem_pkg::RECOV_PULSES)
      else $error("too many recovery pulses");
endmodule
`default_nettype wire

// file: tb/twem_dev_model.sv
// Behavioural model of the two-wire serial EEPROM device
`timescale 1ns/1ps
`default_nettype none
module twem_dev_model #(
   parameter logic [3:0] TYPE    = 4'h5, // Arbitrary type code
   parameter logic [2:0] SEL     = 3'h2,
   parameter logic       WP      = 1'b0,
   parameter real        BUSY_NS = 25000.0
) (
   input  wire logic scl,
   input  wire logic sda,
   output logic      pull
);
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_AHI, S_ALO, S_WR, S_RD} twem_dst_t;
   twem_dst_t   st = S_IDLE;
   logic [7:0]  mem [32768];
   logic [7:0]  pbuf [64];
   logic [63:0] pval = '0;
   logic [14:0] ptr = '0;
   logic [7:0]  sh, dat;
   logic        mack, ack, ld;
   int          bc;
   int          refused = 0;
   real         busy_until = 0.0;

   // Known pattern so reads can be predicted
   initial begin
      pull = 1'b0;
      for (int i = 0; i < 32768; i++)
         mem[i] = 8'(i) ^ 8'h5A;
   end

   // Start abandons whatever was going on
   always @(negedge sda) if (scl) begin
      st = S_ADDR;
      bc = -1;
      pull = 1'b0;
      pval = '0;
   end

   // Stop goes idle and programs the buffered page in one go
   always @(posedge sda) if (scl) begin
      st = S_IDLE;
      pull = 1'b0;
      if (pval != '0 && !WP) begin
         for (int i = 0; i < 64; i++)
            if (pval[i]) mem[{ptr[14:6], 6'(i)}] = pbuf[i];
         busy_until = $realtime + BUSY_NS;
      end
      pval = '0;
   end

   // Bits are taken while the clock is high
   always @(posedge scl) if (st != S_IDLE) begin
      if (bc < 8) sh = {sh[6:0], sda};
      else mack = !sda;
   end

   // Outputs only change while the clock is low, never mimicking start or stop
   always @(negedge scl) if (st != S_IDLE) begin
      bc = bc + 1;
      if (bc == 8) begin
         ack = 1'b1;
         case (st)
            S_ADDR: begin
               ack = sh[7:1] == {TYPE, SEL} && $realtime >= busy_until;
               if (!ack) refused++;
               st = !ack ? S_IDLE : sh[0] ? S_RD : S_AHI;
               ld = 1'b1;
            end
            S_AHI: begin
               ptr[14:8] = sh[6:0];
               st = S_ALO;
            end
            S_ALO: begin
               ptr[7:0] = sh;
               st = S_WR;
            end
            S_WR: begin
               pbuf[ptr[5:0]] = sh;
               pval[ptr[5:0]] = 1'b1;
               ptr[5:0] = ptr[5:0] + 6'h01;
            end
            default: begin
               ack = 1'b0;
               ptr = ptr + 15'h0001;
            end
         endcase
         pull = ack;
      end else if (bc == 9) begin
         bc = 0;
         pull = 1'b0;
         if (st == S_RD && (ld || mack)) begin
            dat = mem[ptr];
            ld = 1'b0;
            pull = !dat[7];
         end else if (st == S_RD) st = S_IDLE;
      end else if (st == S_RD && bc > 0) pull = !dat[3'(7 - bc)];
   end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the two-wire EEPROM master
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [3:0] TYPE = 4'h5; // Arbitrary type code
   localparam logic [2:0] SEL  = 3'h2;
   logic                  ref_clk = 1'b0;
   logic                  rst_n = 1'b0;
   twem_pkg::twem_cmd_t   cmd = '0;
   logic                  cmd_valid = 1'b0;
   logic [7:0]            wr_data = 8'h00;
   logic                  wr_valid = 1'b0;
   logic                  cmd_ready, wr_ready, rd_valid, done, nack_err, busy_err;
   logic [7:0]            rd_data;
   logic                  scl, sda_o, sda_oe, dev_pull;
   wire                   sda_w;
   logic [7:0]            got [$];
   logic [7:0]            wd [4] = '{8'hC3, 8'h3C, 8'h81, 8'h7E};
   logic [14:0]           wa [4] = '{15'h7FFE, 15'h7FFF, 15'h7FC0, 15'h7FC1};
   int                    bad_count = 0;
   int                    cmp_count = 0;
   int                    r0;

   // Open drain with pull-up: low whenever either party pulls
   assign sda_w = !(sda_oe || dev_pull);
   always #2 ref_clk = !ref_clk;

   twem_ctrl #(.WR_CYC(20000), .DEV_TYPE(TYPE)) u_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .cmd(cmd), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .wr_data(wr_data), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid), .done(done),
      .nack_err(nack_err), .busy_err(busy_err), .scl_o(scl), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe(sda_oe));

   twem_dev_model #(.TYPE(TYPE), .SEL(SEL)) u_dev (
      .scl(scl), .sda(sda_w), .pull(dev_pull));

   function automatic logic [7:0] pat(input int a);
      return 8'(a) ^ 8'h5A;
   endfunction

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic push(input logic [7:0] d);
      @(negedge ref_clk);
      while (wr_ready !== 1'b1) @(negedge ref_clk);
      wr_data = d;
      wr_valid = 1'b1;
      @(negedge ref_clk);
      wr_valid = 1'b0;
   endtask

   // One command, bounded wait for done, read bytes collected on the way
   task automatic run(input twem_pkg::twem_op_t op, input logic [2:0] s,
                      input logic [14:0] a, input logic [6:0] n);
      int k;
      got = {};
      @(negedge ref_clk);
      while (cmd_ready !== 1'b1) @(negedge ref_clk);
      cmd = '{op: op, sel: s, addr: a, len: n};
      cmd_valid = 1'b1;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      for (k = 0; k < 80000 && done !== 1'b1; k++) begin
         @(negedge ref_clk);
         if (rd_valid === 1'b1) got.push_back(rd_data);
      end
      chk(16'(k < 80000), 16'h0001);
   endtask

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Watchdog: the sequence needs roughly 115k cycles
   initial begin
      #600000;
      bad_count++;
      finish_test();
   end

   // Main sequence
   initial begin
      repeat (10) @(negedge ref_clk);
      rst_n = 1'b1;
      // Wrong select bits: nobody answers
      run(twem_pkg::OP_CUR_READ, 3'h5, 15'h0000, 7'h01);
      chk(16'(nack_err), 16'h0001);
      chk(16'(got.size()), 16'h0000);
      chk(16'(sda_o), 16'h0000);
      run(twem_pkg::OP_RECOVER, SEL, 15'h0000, 7'h01);
      chk(16'(nack_err), 16'h0000);
      // Fill the buffer, then a page write that wraps inside its page
      for (int i = 0; i < 4; i++)
         push(wd[i]);
      chk(16'(wr_ready), 16'h0000);
      r0 = u_dev.refused;
      run(twem_pkg::OP_WRITE, SEL, 15'h7FFE, 7'h04);
      chk(16'(nack_err), 16'h0000);
      chk(16'(busy_err), 16'h0000);
      chk(16'(u_dev.refused > r0), 16'h0001);
      chk(16'(wr_ready), 16'h0001);
      for (int i = 0; i < 4; i++)
         chk(16'(u_dev.mem[wa[i]]), 16'(wd[i]));
      // Counter sits one past the last byte written
      run(twem_pkg::OP_CUR_READ, SEL, 15'h0000, 7'h01);
      chk(16'(got.size()), 16'h0001);
      chk(16'(got[0]), 16'(pat(32'h7FC2)));
      // Random read across the top of the array
      run(twem_pkg::OP_READ, SEL, 15'h7FFF, 7'h02);
      chk(16'(got.size()), 16'h0002);
      chk(16'(got[0]), 16'(wd[1]));
      chk(16'(got[1]), 16'(pat(0)));
      chk(16'(nack_err), 16'h0000);
      finish_test();
   end
endmodule
`default_nettype wire
